// [stepper_move_profile_generator.sv]
// Move-profile generator: register port, planner, rate ramp and step output
`default_nettype none
module stepper_move_profile_generator #(
  parameter int unsigned MS_TICKS = stepper_profile_pkg::MS_CYCLES
) (
  input  wire logic                                 clock_i,
  input  wire logic                                 rst_i,
  input  wire logic [stepper_profile_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [stepper_profile_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                                 wr_i,
  input  wire logic                                 rd_i,
  output logic      [stepper_profile_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                                 home_reached_i,
  output logic                                      step_o,
  output logic                                      dir_o,
  output logic                                      busy_o,
  output logic                                      error_o,
  output logic                                      enc_clear_o
);
  import stepper_profile_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic rate_ok(input logic [RATE_W-1:0] r);
    return (r >= RATE_MIN) && (r <= RATE_MAX);
  endfunction

  // Average ramp slope per ms for the selected ramp shape
  function automatic logic [RATE_W-1:0] shape_rate(
    input logic [RATE_W-1:0] a, input logic [JERK_W-1:0] j);
    logic [RATE_W-1:0] r;
    r = a;
    if (j == JERK_TRI) begin
      r = a >> 1;
    end else if (j != JERK_LIN) begin
      r = a - (a >> 2);
    end
    return (r == '0) ? RATE_MIN : r;
  endfunction

  function automatic logic signed [31:0] step_pos(
    input logic signed [31:0] p, input logic cw, input logic f32);
    if (cw) begin
      return (f32 || p != POS_MW_MAX) ? p + 32'sh1 : POS_MW_MIN;
    end
    return (f32 || p != POS_MW_MIN) ? p - 32'sh1 : POS_MW_MAX;
  endfunction

  function automatic logic [PROD_W-1:0] span(
    input logic [RATE_W-1:0] hi, input logic [RATE_W-1:0] lo);
    return PROD_W'(hi) * PROD_W'(hi) - PROD_W'(lo) * PROD_W'(lo);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  state_t                   state_q;
  logic signed [31:0]       tgt_q, load_q, pos_q;
  logic [RATE_W-1:0]        spd_q, acc_q, dec_q, base_q;
  logic [RATE_W-1:0]        vc_q, vb_q, ae_q, de_q, rate_q;
  logic [JERK_W-1:0]        jerk_q;
  logic [CMD_W-1:0]         cmd_q;
  logic                     fmt32_q, homed_q, trap_q, err_q, bad_q;
  logic                     dir_q, home_mode_q, decel_q, step_q, clr_q;
  logic [DIST_W-1:0]        rem_q;
  logic [NCO_W-1:0]         nco_q;
  logic [31:0]              ms_cnt_q;
  logic [DATA_W-1:0]        rdata_q;

  logic wr_ctrl, go_move, go_load, home_hit, fire, ms_tick, zero_c;
  logic bad_c, dir_c;
  logic signed [DIST_W-1:0] delta_c;
  logic [NCO_W-1:0]         nco_sum;

  assign wr_ctrl  = wr_i && addr_i == OFF_CTRL;
  assign go_move  = wr_ctrl && state_q == ST_IDLE &&
                    (wdata_i[CMD_W-1:0] == CMD_REL ||
                     wdata_i[CMD_W-1:0] == CMD_ABS ||
                     wdata_i[CMD_W-1:0] == CMD_HOME_CW ||
                     wdata_i[CMD_W-1:0] == CMD_HOME_CCW);
  assign go_load  = wr_ctrl && state_q == ST_IDLE &&
                    wdata_i[CMD_W-1:0] == CMD_LOAD;
  assign home_hit = state_q == ST_RUN && home_mode_q && home_reached_i;
  assign nco_sum  = nco_q + NCO_W'(rate_q);
  assign fire     = state_q == ST_RUN && !home_hit && nco_sum >= NCO_TOP;
  assign ms_tick  = ms_cnt_q == MS_TICKS - 1;
  assign zero_c   = rem_q == '0 && !home_mode_q;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tgt_q   <= '0;
      load_q  <= '0;
      spd_q   <= '0;
      acc_q   <= '0;
      dec_q   <= '0;
      base_q  <= '0;
      jerk_q  <= '0;
      fmt32_q <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        OFF_TARGET: tgt_q   <= wdata_i;
        OFF_SPEED:  spd_q   <= wdata_i[RATE_W-1:0];
        OFF_ACCEL:  acc_q   <= wdata_i[RATE_W-1:0];
        OFF_DECEL:  dec_q   <= wdata_i[RATE_W-1:0];
        OFF_JERK:   jerk_q  <= wdata_i[JERK_W-1:0];
        OFF_BASE:   base_q  <= wdata_i[RATE_W-1:0];
        OFF_CFG:    fmt32_q <= wdata_i[CFG_FMT32];
        OFF_LOAD:   load_q  <= wdata_i;
        default:    tgt_q   <= tgt_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Planner: validate, direction and distance
  // ------------------------------------------------------------
  always_comb begin
    bad_c = !rate_ok(base_q) || !rate_ok(spd_q) || spd_q < base_q ||
            acc_q == '0 || dec_q == '0 || jerk_q > JERK_MAX;
    if (cmd_q != CMD_HOME_CW && cmd_q != CMD_HOME_CCW &&
        (tgt_q > TGT_MAX || tgt_q < TGT_MIN)) begin
      bad_c = 1'b1;
    end
    if (cmd_q == CMD_ABS) begin
      delta_c = DIST_W'(tgt_q) - DIST_W'(pos_q);
    end else begin
      delta_c = DIST_W'(tgt_q);
    end
    if (cmd_q == CMD_HOME_CW || cmd_q == CMD_HOME_CCW) begin
      dir_c = cmd_q == CMD_HOME_CW;
    end else begin
      dir_c = delta_c > 0;
    end
  end

  // Ramps live in the per-ms unit; scaled by 1000 in the planner and in the decel start check
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmd_q       <= '0;
      bad_q       <= 1'b0;
      dir_q       <= 1'b0;
      home_mode_q <= 1'b0;
      ae_q        <= '0;
      de_q        <= '0;
      vc_q        <= '0;
      vb_q        <= '0;
    end else if (go_move) begin
      cmd_q <= wdata_i[CMD_W-1:0];
    end else if (state_q == ST_CALC) begin
      bad_q       <= bad_c;
      dir_q       <= dir_c;
      home_mode_q <= cmd_q == CMD_HOME_CW || cmd_q == CMD_HOME_CCW;
      ae_q        <= shape_rate(acc_q, jerk_q);
      de_q        <= shape_rate(dec_q, jerk_q);
      vc_q        <= spd_q;
      vb_q        <= base_q;
    end
  end

  // Trapezoid when accel plus decel distance fits inside the move
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      trap_q <= 1'b0;
    end else if (state_q == ST_PLAN) begin
      trap_q <= span(vc_q, vb_q) * (PROD_W'(ae_q) + PROD_W'(de_q)) <
                PROD_W'(ae_q) * PROD_W'(de_q) * (ACC_SCALE << 1) *
                PROD_W'(rem_q);
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (go_move) state_q <= ST_CALC;
        ST_CALC: state_q <= ST_PLAN;
        ST_PLAN: begin
          // Steps begin only after the plan is complete
          state_q <= (bad_q || zero_c) ? ST_IDLE : ST_RUN;
        end
        ST_RUN: begin
          if (home_hit || (fire && !home_mode_q && rem_q == 1)) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else if (state_q == ST_PLAN && bad_q) begin
      err_q <= 1'b1;
    end else if (go_move) begin
      err_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Distance, rate ramp and step timing
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rem_q <= '0;
    end else if (state_q == ST_CALC) begin
      rem_q <= delta_c < 0 ? -delta_c : delta_c;
    end else if (fire && !home_mode_q) begin
      rem_q <= rem_q - DIST_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || state_q != ST_RUN || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  // Decel starts once the distance left only just covers the ramp down
  always_ff @(posedge clock_i) begin
    if (rst_i || state_q != ST_RUN) begin
      decel_q <= 1'b0;
    end else if (!home_mode_q && PROD_W'(rem_q) * PROD_W'(de_q) *
                 (ACC_SCALE << 1) <= span(rate_q, vb_q)) begin
      decel_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rate_q <= '0;
    end else if (state_q == ST_PLAN) begin
      rate_q <= base_q;
    end else if (state_q != ST_RUN) begin
      rate_q <= '0;
    end else if (ms_tick && decel_q) begin
      // One bit of headroom: base plus decel can pass the rate field width
      rate_q <= ((RATE_W+1)'(rate_q) >
                 (RATE_W+1)'(vb_q) + (RATE_W+1)'(de_q)) ?
                rate_q - de_q : vb_q;
    end else if (ms_tick && rate_q < vc_q) begin
      rate_q <= ((RATE_W+1)'(rate_q) + (RATE_W+1)'(ae_q) <
                 (RATE_W+1)'(vc_q)) ? rate_q + ae_q : vc_q;
    end
  end

  // Phase accumulator: one step each time it passes the clock rate
  always_ff @(posedge clock_i) begin
    if (rst_i || state_q != ST_RUN) begin
      nco_q <= '0;
    end else begin
      nco_q <= fire ? nco_sum - NCO_TOP : nco_sum;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      step_q <= 1'b0;
      clr_q  <= 1'b0;
    end else begin
      step_q <= fire;
      clr_q  <= home_hit;
    end
  end

  // ------------------------------------------------------------
  // Motor position
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pos_q <= '0;
    end else if (home_hit) begin
      pos_q <= '0;
    end else if (go_load) begin
      if (fmt32_q) begin
        pos_q <= load_q;
      end else begin
        pos_q <= load_q > POS_MW_MAX ? POS_MW_MAX :
                 load_q < POS_MW_MIN ? POS_MW_MIN : load_q;
      end
    end else if (fire) begin
      pos_q <= step_pos(pos_q, dir_q, fmt32_q);
    end
  end

  // Reference flag for the host; absolute moves are not blocked by it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      homed_q <= 1'b0;
    end else if (go_load || home_hit) begin
      homed_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i || !rd_i) begin
      rdata_q <= '0;
    end else begin
      case (addr_i)
        OFF_TARGET: rdata_q <= tgt_q;
        OFF_SPEED:  rdata_q <= DATA_W'(spd_q);
        OFF_ACCEL:  rdata_q <= DATA_W'(acc_q);
        OFF_DECEL:  rdata_q <= DATA_W'(dec_q);
        OFF_JERK:   rdata_q <= DATA_W'(jerk_q);
        OFF_BASE:   rdata_q <= DATA_W'(base_q);
        OFF_CFG:    rdata_q <= DATA_W'(fmt32_q);
        OFF_LOAD:   rdata_q <= load_q;
        OFF_STATUS: rdata_q <= DATA_W'({dir_q, trap_q, homed_q, err_q,
                                        state_q != ST_IDLE});
        OFF_POS:    rdata_q <= pos_q;
        OFF_RATE:   rdata_q <= DATA_W'(rate_q);
        default:    rdata_q <= '0;
      endcase
    end
  end

  assign rdata_o     = rdata_q;
  assign step_o      = step_q;
  assign dir_o       = dir_q;
  assign busy_o      = state_q != ST_IDLE;
  assign error_o     = err_q;
  assign enc_clear_o = clr_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_reject;
    state_q == ST_PLAN && bad_q;
  endsequence

  sequence s_start;
    state_q == ST_PLAN && !bad_q && !zero_c;
  endsequence

  a_reject_no_step: assert property (
    s_reject |=> error_o && !busy_o ##1 !step_o)
    else $error("rejected move left error low or stepped");

  a_start_at_base: assert property (
    s_start |=> state_q == ST_RUN && rate_q == vb_q && !step_o)
    else $error("move did not start at base rate");

  a_step_after_plan: assert property (
    step_o |-> $past(state_q) == ST_RUN)
    else $error("step outside a planned run");

  a_cw_count_up: assert property (
    step_o && dir_o && (fmt32_q || $past(pos_q) != POS_MW_MAX)
    |-> pos_q == $past(pos_q) + 32'sh1)
    else $error("clockwise step did not increment position");

  a_ccw_count_down: assert property (
    step_o && !dir_o && (fmt32_q || $past(pos_q) != POS_MW_MIN)
    |-> pos_q == $past(pos_q) - 32'sh1)
    else $error("counter-clockwise step did not decrement position");

  a_load_range_mw: assert property (
    go_load && !fmt32_q |=> pos_q <= POS_MW_MAX && pos_q >= POS_MW_MIN)
    else $error("loaded position outside multi-word range");

  a_load_exact: assert property (
    go_load && fmt32_q |=> pos_q == $past(load_q) && !busy_o)
    else $error("position load value not taken");

  a_home_zeroes: assert property (
    home_hit |=> pos_q == '0 && enc_clear_o && !busy_o ##1 !enc_clear_o)
    else $error("home point did not zero positions");

  a_rate_window: assert property (
    state_q == ST_RUN |-> rate_q >= vb_q && rate_q <= vc_q)
    else $error("step rate outside base to cruise");

  a_rel_direction: assert property (
    state_q == ST_CALC && cmd_q == CMD_REL
    |=> dir_q == ($past(tgt_q) > 32'sh0))
    else $error("relative move direction wrong");

  a_abs_direction: assert property (
    state_q == ST_CALC && cmd_q == CMD_ABS
    |=> dir_q == ($past(tgt_q) > $past(pos_q)))
    else $error("absolute move direction wrong");

  a_decel_holds: assert property (
    decel_q && state_q == ST_RUN && !$changed(state_q)
    |=> decel_q || state_q == ST_IDLE)
    else $error("deceleration dropped mid move");
endmodule
`default_nettype wire

// [stepper_profile_pkg.sv]
// Constants, types and register map for the stepper move-profile generator
// Functional notes
// - Whole profile is planned before any step is made or any error shown.
// - Accel and decel are programmed per millisecond; planning scales by 1000.
// - Default position format spans -32,768,000 to +32,767,999 counts.
// - Double integer format makes position a full signed 32-bit count.
// - Position load writes a host value into position without motion.
// - Home search at the home point zeroes motor and encoder positions.
// - Clockwise steps count position up, counter-clockwise steps count down.
// - Base step rate accepted only from 1 to 1,999,999 steps per second.
// - Relative target is a signed offset within 8,388,607; sign gives direction.
// - Absolute target within 8,388,607; above position is clockwise, below not.
// - All supported moves, homing included, take a ramp-shape selector.
// - Selector zero gives linear ramps at constant acceleration.
// - Selector one gives triangular S-curve ramps taking twice linear time.
// - Selector 2 to 5000 gives trapezoidal S-curve ramps.
// - Trapezoidal S-curve with half constant section takes 33% longer.
// - Move starts at base rate then accelerates toward cruise rate.
// - Cruise rate holds until remaining distance equals deceleration distance.
// - Deceleration uses its own value and ends at base rate on target.
// - Ramps shorter than the move give a trapezoid reaching cruise rate.
// - Ramps longer than the move give a triangle never reaching cruise.
`default_nettype none
package stepper_profile_pkg;
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned MS_PER_S  = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RATE_W = 21;
  localparam int JERK_W = 13;
  localparam int CMD_W  = 3;
  localparam int DIST_W = 33;
  localparam int NCO_W  = 28;
  localparam int PROD_W = 80;

  localparam logic [NCO_W-1:0]  NCO_TOP   = 28'h773_5940;
  localparam logic [PROD_W-1:0] ACC_SCALE = 80'h3e8;
  localparam logic [RATE_W-1:0] RATE_MIN  = 21'h00_0001;
  localparam logic [RATE_W-1:0] RATE_MAX  = 21'h1e_847f;
  localparam logic [JERK_W-1:0] JERK_LIN  = 13'h0000;
  localparam logic [JERK_W-1:0] JERK_TRI  = 13'h0001;
  localparam logic [JERK_W-1:0] JERK_MAX  = 13'h1388;

  localparam logic signed [31:0] TGT_MAX    = 32'sh007f_ffff;
  localparam logic signed [31:0] TGT_MIN    = -32'sh007f_ffff;
  localparam logic signed [31:0] POS_MW_MAX = 32'sh01f3_ffff;
  localparam logic signed [31:0] POS_MW_MIN = 32'shfe0c_0000;

  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_TARGET = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SPEED  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ACCEL  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DECEL  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_JERK   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_BASE   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CFG    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_LOAD   = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_POS    = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_RATE   = 8'h2c;

  localparam int CFG_FMT32  = 0;
  localparam int ST_BUSY    = 0;
  localparam int ST_ERROR   = 1;
  localparam int ST_HOMED   = 2;
  localparam int ST_TRAP    = 3;
  localparam int ST_DIR     = 4;

  localparam logic [CMD_W-1:0] CMD_REL      = 3'h1;
  localparam logic [CMD_W-1:0] CMD_ABS      = 3'h2;
  localparam logic [CMD_W-1:0] CMD_LOAD     = 3'h3;
  localparam logic [CMD_W-1:0] CMD_HOME_CW  = 3'h4;
  localparam logic [CMD_W-1:0] CMD_HOME_CCW = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_PLAN = 2'b11,
    ST_RUN  = 2'b10
  } state_t;
endpackage
`default_nettype wire

// [home_sensor_model.sv]
// Home sensor model: reports the home point after a set number of steps
`default_nettype none
module home_sensor_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       step_i,
  input  wire logic       arm_i,
  input  wire logic [7:0] after_i,
  output logic            home_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seen_q;
  // ----------------------------------------------------------------------
  // Step counting
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i || !arm_i) begin
      seen_q <= 8'h00;
    end else if (step_i) begin
      seen_q <= seen_q + 8'h01;
    end
  end
  // Quiet unless armed, so a stray level cannot cut short an ordinary move
  assign home_o = arm_i && (seen_q >= after_i);
endmodule
`default_nettype wire

// [stepper_move_profile_generator_tb.sv]
// Self-checking bench for the stepper move-profile generator
`default_nettype none
module stepper_move_profile_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stepper_profile_pkg::*;
  localparam logic [31:0] BASE = 32'h000f_4240;
  localparam logic [31:0] ACC  = 32'h0000_03e8;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        arm     = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  after   = 8'h05;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [31:0] rdata, v, p;
  logic        step, dir, busy, err, eclr, home;
  logic        exp_dir = 1'b1;
  int          n_fail = 0, cmp_count = 0, nstep = 0, nclr = 0;
  int          early = 0, dirbad = 0, cyc = 0, c0 = 0, s, c;
  logic [7:0]  ba [9] = '{OFF_BASE, OFF_BASE, OFF_SPEED, OFF_SPEED,
                          OFF_ACCEL, OFF_DECEL, OFF_JERK, OFF_TARGET,
                          OFF_TARGET};
  logic [31:0] bd [9] = '{32'h0, 32'h1e_8480, 32'h1e_8480, 32'h0f_423f,
                          32'h0, 32'h0, 32'h1389, 32'h80_0000,
                          32'hff80_0000};
  logic [2:0]  bc [9] = '{CMD_REL, CMD_REL, CMD_REL, CMD_REL, CMD_REL,
                          CMD_REL, CMD_HOME_CW, CMD_ABS, CMD_ABS};
  logic [31:0] lv [5] = '{32'h64, 32'h0262_5a00, 32'hfd9d_a600,
                          32'h7fff_ffff, 32'h8000_0000};
  logic [31:0] le [5] = '{32'h64, 32'h01f3_ffff, 32'hfe0c_0000,
                          32'h7fff_ffff, 32'h8000_0000};

  initial begin
    forever #4 clock_i = ~clock_i;
  end

  stepper_move_profile_generator #(.MS_TICKS(10)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .home_reached_i(home),
    .step_o(step), .dir_o(dir), .busy_o(busy), .error_o(err),
    .enc_clear_o(eclr));

  home_sensor_model sensor (.clock_i(clock_i), .rst_i(rst_i),
    .step_i(step), .arm_i(arm), .after_i(after), .home_o(home));

  // ----------------------------------------------------------------------
  // Step, direction and encoder-clear monitor
  // ----------------------------------------------------------------------
  always @(posedge clock_i) begin
    cyc++;
    if (wr && addr == OFF_CTRL) c0 = cyc;
    if (step === 1'b1) begin
      nstep++;
      if (cyc - c0 < 4) early++;
      if (dir !== exp_dir) dirbad++;
    end
    if (eclr === 1'b1) nclr++;
  end

  // ----------------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Extra edge lets the monitor count a step that lands with busy low
  task automatic idle();
    int n;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 60000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    @(posedge clock_i);
    #1;
    if (n >= 60000) begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic go(input logic [2:0] cmd);
    wr_reg(OFF_CTRL, {29'h0, cmd});
    idle();
  endtask

  task automatic prm(input logic [31:0] b, sp, a, d, j, t);
    wr_reg(OFF_BASE, b);
    wr_reg(OFF_SPEED, sp);
    wr_reg(OFF_ACCEL, a);
    wr_reg(OFF_DECEL, d);
    wr_reg(OFF_JERK, j);
    wr_reg(OFF_TARGET, t);
  endtask

  task automatic ld(input logic [31:0] val);
    wr_reg(OFF_LOAD, val);
    go(CMD_LOAD);
  endtask

  task automatic move(input logic [2:0] cmd, input logic [31:0] t,
                      input logic [31:0] pos, input int n, input logic d);
    prm(BASE, BASE, ACC, ACC, 32'h0, t);
    exp_dir = d;
    s = nstep;
    go(cmd);
    chk32(nstep - s, n);
    rd_reg(OFF_POS, v);
    chk32(v, pos);
    chkb(err, 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk32({28'h0, busy, step, err, eclr}, 32'h0);
    rd_reg(OFF_STATUS, v);
    chk32(v, 32'h0);
    rd_reg(OFF_POS, v);
    chk32(v, 32'h0);
    rd_reg(OFF_CTRL, v);
    chk32(v, 32'h0);
    rd_reg(8'hfc, v);
    chk32(v, 32'h0);
  endtask

  task automatic t_load();
    s = nstep;
    for (int i = 0; i < 5; i++) begin
      wr_reg(OFF_CFG, (i > 2) ? 32'h1 : 32'h0);
      ld(lv[i]);
      wr_reg(8'hfc, 32'h0000_1234);
      rd_reg(OFF_POS, v);
      chk32(v, le[i]);
    end
    chk32(nstep - s, 32'h0);
    wr_reg(OFF_CFG, 32'h0);
  endtask

  task automatic t_reject();
    for (int i = 0; i < 9; i++) begin
      prm(BASE, BASE, ACC, ACC, 32'h0, 32'h3);
      wr_reg(ba[i], bd[i]);
      s = nstep;
      go(bc[i]);
      chkb(err, 1'b1);
      chk32(nstep - s, 32'h0);
    end
  endtask

  task automatic t_home();
    for (int k = 0; k < 2; k++) begin
      ld(32'h32);
      prm(BASE, BASE, ACC, ACC, 32'h1388, 32'h0);
      exp_dir = (k == 0);
      @(posedge clock_i);
      arm <= 1'b1;
      s = nstep;
      c = nclr;
      go((k == 0) ? CMD_HOME_CW : CMD_HOME_CCW);
      @(posedge clock_i);
      arm <= 1'b0;
      chk32(nstep - s, 32'h5);
      chk32(nclr - c, 32'h1);
      rd_reg(OFF_POS, v);
      chk32(v, 32'h0);
      rd_reg(OFF_STATUS, v);
      chkb(v[ST_HOMED], 1'b1);
    end
  endtask

  // Slope per tick: full, half and three quarters of the programmed value
  task automatic t_shape();
    int m;
    for (int j = 0; j < 3; j++) begin
      m = (j == 0) ? 4 : (j == 1) ? 2 : 3;
      exp_dir = 1'b1;
      prm(BASE, 32'h1c_fde0, 32'h4e20, 32'h1e_8480, j, 32'h96);
      wr_reg(OFF_CTRL, {29'h0, CMD_REL});
      @(posedge clock_i);
      rd_reg(OFF_RATE, v);
      chk32(v, BASE);
      repeat (95) @(posedge clock_i);
      rd_reg(OFF_RATE, v);
      chkb(v >= BASE + 45000 * m && v <= BASE + 55000 * m, 1'b1);
      idle();
    end
  endtask

  task automatic t_profile();
    for (int k = 0; k < 2; k++) begin
      rd_reg(OFF_POS, p);
      prm(BASE, 32'h10_c8e0, 32'h1e_8480, 32'h1e_8480, 32'h0,
          (k == 0) ? 32'h3c : 32'h96);
      wr_reg(OFF_CTRL, {29'h0, CMD_REL});
      repeat (3) @(posedge clock_i);
      rd_reg(OFF_STATUS, v);
      chkb(v[ST_TRAP], k[0]);
      idle();
      rd_reg(OFF_POS, v);
      chk32(v - p, (k == 0) ? 32'h3c : 32'h96);
    end
  endtask

  initial begin
    #800_000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_reset();
    t_load();
    t_reject();
    ld(32'h0);
    move(CMD_REL, 32'h3, 32'h3, 3, 1'b1);
    move(CMD_REL, 32'hffff_fffd, 32'h0, 3, 1'b0);
    ld(32'ha);
    move(CMD_ABS, 32'h7, 32'h7, 3, 1'b0);
    move(CMD_ABS, 32'hc, 32'hc, 5, 1'b1);
    t_home();
    t_shape();
    t_profile();
    chk32(early, 32'h0);
    chk32(dirbad, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
